// [dafd_pkg.sv]
// What this block does
// - Low four function bits select the operation
// - Commands accepted only while interface not busy
// - Code E pseudo output latches file pointer
// - Input code 0 returns pointed file register
// - Code 1 posts request flag per bit 4
// - Code 1 bits 5,6 clear seek flags
// - Any seek clears seek-complete status
// - Seek-initiated sets at seek, clears at end
// - Drive request needs idle and formatter selected
// - Drive request leaves drive selection unchanged
// - Code 8 value 0001 resets interface conditions
// - Other code 8 sets enables, forwards connects
// - Code 3 selects one of sixteen drives
// - Codes D/E load 18-bit word address
// - Code C clears flagged status bits 0-6
// - Code 7 stores head/sector value
// - Code 5 stores cylinder, starts seek
// - Code C 0080 homes heads, clears seek error
// - Code 6 zero erases selected track
// - Code A starts write, data or address
// - Code 9 starts read, data or address
// - Code B manipulates ECC bytes per bits 4,5
// - Input code A returns ECC bits 11-18
// - Zero count transfers use 64 FIFO words
// - Code F echoes eight bits via formatter
// - Code 4 echo needs bit 7, returns 0-6
// - Zero word count makes next transfer test-mode
package dafd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PARAM = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // Command register fields
  localparam int CMD_DIR_BIT = 8;
  // Function codes
  localparam logic [3:0] FN_0 = 4'h0;
  localparam logic [3:0] FN_REQ = 4'h1;
  localparam logic [3:0] FN_POLL = 4'h2;
  localparam logic [3:0] FN_SEL = 4'h3;
  localparam logic [3:0] FN_DECHO = 4'h4;
  localparam logic [3:0] FN_CYL = 4'h5;
  localparam logic [3:0] FN_FMT = 4'h6;
  localparam logic [3:0] FN_HS = 4'h7;
  localparam logic [3:0] FN_DIR = 4'h8;
  localparam logic [3:0] FN_RD = 4'h9;
  localparam logic [3:0] FN_WR = 4'hA;
  localparam logic [3:0] FN_ECC = 4'hB;
  localparam logic [3:0] FN_STC = 4'hC;
  localparam logic [3:0] FN_ADLO = 4'hD;
  localparam logic [3:0] FN_ADHI = 4'hE;
  localparam logic [3:0] FN_CECHO = 4'hF;
  // Parameter values and bit positions
  localparam logic [15:0] PV_ZERO = 16'h0000;
  localparam logic [15:0] PV_RESET = 16'h0001;
  localparam logic [15:0] PV_ADDR = 16'h0080;
  localparam int request_flag_control_bit = 4;
  localparam int PB_CLR_CMPL = 5;
  localparam int PB_CLR_INIT = 6;
  localparam int PB_ECHO_ARM = 7;
  localparam int PB_FILE_SEL = 8;
  localparam int PB_ECC_SHIFT = 4;
  localparam int PB_ECC_CLR = 5;
  localparam int PB_POLL_GROUP = 3;
  // Test-mode FIFO transfer length
  localparam logic [15:0] TEST_WORDS = 16'h0040;
  // Busy state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CF = 3'b010,
    ST_XFER = 3'b100
  } state_type;
endpackage

// [dafd_top.sv]
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module dafd_top
  import dafd_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CF_SELECTED,
  input wire logic I_CF_DONE,
  input wire logic [15:0] I_CF_RDATA,
  output logic O_CF_REQ,
  output logic [3:0] O_CF_FUNC,
  output logic [15:0] O_CF_WDATA,
  output logic [3:0] O_CF_UNIT,
  input wire logic [15:0] I_SEEK_END,
  input wire logic I_SEEK_ERR,
  input wire logic [6:0] I_STATUS_SET,
  input wire logic I_ECC_LOAD,
  input wire logic [18:0] I_ECC_DATA,
  output logic O_XFER_START,
  output logic O_XFER_WRITE,
  output logic O_XFER_ADDR_FIELD,
  output logic O_XFER_TEST,
  output logic [15:0] O_XFER_LEN,
  output logic [17:0] O_XFER_ADDR,
  input wire logic I_XFER_DONE,
  output logic [15:0] O_IRQ_ENABLE,
  output logic O_BUSY
);

  // Decoded request of one APB write to the command word
  logic cmd_wr; // Command write taken this cycle
  logic [3:0] primary_function_code; // Low four function bits
  logic is_out; // Output (from host) when high
  logic accept; // Command taken by the idle interface

  // Register state
  state_type state, next_state; // Busy sequencer
  logic [15:0] param, next_param; // Parameter word
  logic [15:0] result, next_result; // Input data to host
  logic [3:0] file_ptr, next_file_ptr; // Working register pointer
  logic [7:0] file_mem [16]; // Sixteen working registers
  logic [3:0] unit, next_unit; // Selected logical drive
  logic [15:0] word_cnt, next_word_cnt; // Buffer length
  logic [17:0] mem_addr, next_mem_addr; // Current word address
  logic [15:0] head_sec, next_head_sec; // Head/sector register
  logic [15:0] cyl, next_cyl; // Cylinder register
  logic [15:0] seek_init, next_seek_init; // Seek-initiated per drive
  logic [15:0] seek_cmpl, next_seek_cmpl; // Seek-complete per drive
  logic seek_err, next_seek_err; // Seek error status
  logic [6:0] gen_stat, next_gen_stat; // General/error status
  logic [15:0] irq_en, next_irq_en; // Interrupt enables
  logic [18:0] ecc, next_ecc; // Error-correction pattern
  logic [7:0] cf_echo, next_cf_echo; // Formatter echo pattern
  logic [6:0] dr_echo, next_dr_echo; // Drive echo pattern
  logic [3:0] cf_op, next_cf_op; // Function pending at formatter
  logic refused, next_refused; // Sticky: command refused
  logic cf_req, next_cf_req; // Formatter strobe
  logic [3:0] cf_func, next_cf_func; // Formatter function
  logic [15:0] cf_wdata, next_cf_wdata; // Formatter data
  logic xs, next_xs; // Transfer start strobe
  logic xw, next_xw; // Transfer is a write
  logic xa, next_xa; // Transfer on address field
  logic xt, next_xt; // Transfer is FIFO test
  logic [15:0] xlen, next_xlen; // Transfer length
  logic [17:0] xaddr, next_xaddr; // Start address held for the transfer
  logic [31:0] prdata, next_prdata; // Registered read data

  // Selects the read-back word for an APB address
  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input logic [15:0] p,
                                          input logic [15:0] r,
                                          input logic [31:0] s);
    case (a)
      OFS_PARAM: rd_mux = {16'h0000, p};
      OFS_RESULT: rd_mux = {16'h0000, r};
      OFS_STATUS: rd_mux = s;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // Test whether an address maps to a register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_PARAM) || (a == OFS_CMD) ||
             (a == OFS_RESULT) || (a == OFS_STATUS);
  endfunction

  // Decode of the command write
  always_comb begin
    cmd_wr = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == OFS_CMD);
    primary_function_code = I_PWDATA[3:0];
    is_out = I_PWDATA[CMD_DIR_BIT];
    accept = cmd_wr && (state == ST_IDLE);
  end

  // Next values of all control state
  always_comb begin
    next_state = state;
    next_param = param;
    next_result = result;
    next_file_ptr = file_ptr;
    next_unit = unit;
    next_word_cnt = word_cnt;
    next_mem_addr = mem_addr;
    next_head_sec = head_sec;
    next_cyl = cyl;
    next_seek_init = seek_init;
    next_seek_cmpl = seek_cmpl;
    next_seek_err = seek_err;
    next_gen_stat = gen_stat;
    next_irq_en = irq_en;
    next_ecc = ecc;
    next_cf_echo = cf_echo;
    next_dr_echo = dr_echo;
    next_cf_op = cf_op;
    next_refused = refused;
    next_cf_req = 1'b0;
    next_cf_func = cf_func;
    next_cf_wdata = cf_wdata;
    next_xs = 1'b0;
    next_xw = xw;
    next_xa = xa;
    next_xt = xt;
    next_xlen = xlen;
    next_xaddr = xaddr;
    next_prdata = prdata;
    // Read data is captured in the setup phase
    if (I_PSEL && !I_PENABLE) begin
      next_prdata = rd_mux(I_PADDR, param,
                           result, {24'h00_0000, state == ST_XFER, seek_err, refused,
                                    4'h0, state != ST_IDLE});
    end
    // Parameter word written by software
    if (I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == OFS_PARAM)) begin
      next_param = I_PWDATA[15:0];
    end
    // Busy commands are refused and flagged
    if (cmd_wr && !accept) begin
      next_refused = 1'b1;
    end
    // Completion from the formatter
    if (state == ST_CF && I_CF_DONE) begin
      next_state = ST_IDLE;
      if (cf_op == FN_CECHO) begin
        next_cf_echo = I_CF_RDATA[7:0];
      end else if (cf_op == FN_DECHO) begin
        next_dr_echo = I_CF_RDATA[6:0];
      end
      next_result = I_CF_RDATA;
    end
    // Completion of a memory transfer
    if (state == ST_XFER && I_XFER_DONE) begin
      next_state = ST_IDLE;
    end
    // Hardware status events
    if (I_ECC_LOAD) begin
      next_ecc = I_ECC_DATA;
    end
    // Accepted output commands
    if (accept && is_out) begin
      next_cf_func = primary_function_code;
      next_cf_wdata = param;
      next_cf_op = primary_function_code;
      case (primary_function_code)
        FN_0: begin
          next_word_cnt = param;
        end
        FN_REQ: begin
          if (I_CF_SELECTED) begin
            // Only a flag is posted; unit stays as is
            next_cf_req = 1'b1;
            next_state = ST_CF;
            if (param[PB_CLR_CMPL]) begin
              next_seek_cmpl[param[3:0]] = 1'b0;
            end
            if (param[PB_CLR_INIT]) begin
              next_seek_init[param[3:0]] = 1'b0;
            end
          end else begin
            next_refused = 1'b1;
          end
        end
        FN_SEL: begin
          next_unit = param[3:0];
          next_cf_req = 1'b1;
          next_state = ST_CF;
        end
        FN_DECHO: begin
          if (param[PB_ECHO_ARM]) begin
            next_cf_wdata = {9'h000, param[6:0]};
            next_cf_req = 1'b1;
            next_state = ST_CF;
          end else begin
            next_refused = 1'b1;
          end
        end
        FN_CYL: begin
          next_cyl = param;
          next_seek_init[unit] = 1'b1;
          next_seek_cmpl[unit] = 1'b0;
          next_cf_req = 1'b1;
          next_state = ST_CF;
        end
        FN_FMT: begin
          if (param == PV_ZERO) begin
            next_cf_req = 1'b1;
            next_state = ST_CF;
          end else begin
            next_refused = 1'b1;
          end
        end
        FN_HS: begin
          next_head_sec = param;
        end
        FN_DIR: begin
          if (param == PV_RESET) begin
            next_irq_en = 16'h0000;
            next_gen_stat = 7'h00;
            next_seek_err = 1'b0;
            next_refused = 1'b0;
          end else begin
            next_irq_en = param;
            next_cf_req = 1'b1;
            next_state = ST_CF;
          end
        end
        FN_RD, FN_WR: begin
          if (param == PV_ZERO || param == PV_ADDR) begin
            // Zero count means a FIFO test of fixed size
            next_xt = (word_cnt == 16'h0000);
            next_xlen = next_xt ? TEST_WORDS : word_cnt;
            next_xw = (primary_function_code == FN_WR);
            next_xa = (param == PV_ADDR);
            next_xs = 1'b1;
            next_xaddr = mem_addr;
            next_state = ST_XFER;
          end else begin
            next_refused = 1'b1;
          end
        end
        FN_ECC: begin
          if (param[PB_ECC_CLR]) begin
            next_ecc = 19'h0_0000;
          end else if (param[PB_ECC_SHIFT]) begin
            next_ecc = {ecc[10:0], 8'h00};
          end
        end
        FN_STC: begin
          if (param == PV_ADDR) begin
            next_seek_err = 1'b0;
            next_cf_req = 1'b1;
            next_state = ST_CF;
          end else begin
            next_gen_stat = gen_stat & ~param[6:0];
          end
        end
        FN_ADLO: begin
          next_mem_addr = {mem_addr[17:16], param};
        end
        FN_ADHI: begin
          if (param[PB_FILE_SEL]) begin
            next_file_ptr = param[3:0];
          end else begin
            next_mem_addr = {param[1:0], mem_addr[15:0]};
          end
        end
        default: begin
          // Poll and formatter echo go to the formatter
          next_cf_req = 1'b1;
          next_state = ST_CF;
        end
      endcase
    end
    // Accepted input commands answer from local state
    if (accept && !is_out) begin
      case (primary_function_code)
        FN_0: next_result = {8'h00, file_mem[file_ptr]};
        FN_DECHO: next_result = {9'h000, dr_echo};
        // Seek flags of one group of eight drives: initiated high byte, complete low byte
        FN_POLL: next_result = param[PB_POLL_GROUP] ? {seek_init[15:8], seek_cmpl[15:8]}
                                                    : {seek_init[7:0], seek_cmpl[7:0]};
        FN_CYL: next_result = cyl;
        FN_HS: next_result = head_sec;
        FN_WR: next_result = {8'h00, ecc[18:11]};
        FN_CECHO: next_result = {8'h00, cf_echo};
        default: next_result = {9'h000, gen_stat};
      endcase
    end
    // Seek end clears initiated, sets complete
    next_seek_cmpl = next_seek_cmpl | I_SEEK_END;
    next_seek_init = next_seek_init & ~I_SEEK_END;
    // Set wins over the clears above
    next_gen_stat = next_gen_stat | I_STATUS_SET;
    next_seek_err = next_seek_err | I_SEEK_ERR;
  end

  // Working registers take formatter replies by function slot
  always_ff @(posedge I_CORE_CLK) begin
    if (state == ST_CF && I_CF_DONE) begin
      file_mem[cf_op] <= I_CF_RDATA[7:0];
    end
  end

  // State registers
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
      param <= 16'h0000;
      result <= 16'h0000;
      file_ptr <= 4'h0;
      unit <= 4'h0;
      word_cnt <= 16'h0000;
      mem_addr <= 18'h0_0000;
      head_sec <= 16'h0000;
      cyl <= 16'h0000;
      seek_init <= 16'h0000;
      seek_cmpl <= 16'h0000;
      seek_err <= 1'b0;
      gen_stat <= 7'h00;
      irq_en <= 16'h0000;
      ecc <= 19'h0_0000;
      cf_echo <= 8'h00;
      dr_echo <= 7'h00;
      cf_op <= 4'h0;
      refused <= 1'b0;
      cf_req <= 1'b0;
      cf_func <= 4'h0;
      cf_wdata <= 16'h0000;
      xs <= 1'b0;
      xw <= 1'b0;
      xa <= 1'b0;
      xt <= 1'b0;
      xlen <= 16'h0000;
      xaddr <= 18'h0_0000;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      param <= next_param;
      result <= next_result;
      file_ptr <= next_file_ptr;
      unit <= next_unit;
      word_cnt <= next_word_cnt;
      mem_addr <= next_mem_addr;
      head_sec <= next_head_sec;
      cyl <= next_cyl;
      seek_init <= next_seek_init;
      seek_cmpl <= next_seek_cmpl;
      seek_err <= next_seek_err;
      gen_stat <= next_gen_stat;
      irq_en <= next_irq_en;
      ecc <= next_ecc;
      cf_echo <= next_cf_echo;
      dr_echo <= next_dr_echo;
      cf_op <= next_cf_op;
      refused <= next_refused;
      cf_req <= next_cf_req;
      cf_func <= next_cf_func;
      cf_wdata <= next_cf_wdata;
      xs <= next_xs;
      xw <= next_xw;
      xa <= next_xa;
      xt <= next_xt;
      xlen <= next_xlen;
      xaddr <= next_xaddr;
      prdata <= next_prdata;
    end
  end

  // Port drive
  always_comb begin
    O_PRDATA = prdata;
    O_PREADY = 1'b1;
    O_PSLVERR = I_PSEL && I_PENABLE && !mapped(I_PADDR);
    O_CF_REQ = cf_req;
    O_CF_FUNC = cf_func;
    O_CF_WDATA = cf_wdata;
    O_CF_UNIT = unit;
    O_XFER_START = xs;
    O_XFER_WRITE = xw;
    O_XFER_ADDR_FIELD = xa;
    O_XFER_TEST = xt;
    O_XFER_LEN = xlen;
    O_XFER_ADDR = xaddr;
    O_IRQ_ENABLE = irq_en;
    O_BUSY = (state != ST_IDLE);
  end

endmodule

// [dafd_checker_props.sv]
`timescale 1ns/1ps
// Port-level watch on decode, handshake and transfer set-up
module dafd_checker
  import dafd_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_CF_SELECTED,
  input wire logic I_CF_DONE,
  input wire logic I_XFER_DONE,
  input wire logic O_PSLVERR,
  input wire logic O_CF_REQ,
  input wire logic [3:0] O_CF_FUNC,
  input wire logic O_XFER_START,
  input wire logic O_XFER_TEST,
  input wire logic [15:0] O_XFER_LEN,
  input wire logic [17:0] O_XFER_ADDR,
  input wire logic O_BUSY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // Command word taken at an access edge
  logic cmd_wr;
  assign cmd_wr = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == OFS_CMD);
  a_req_one_cycle: assert property (O_CF_REQ |=> !O_CF_REQ)
    else $error("request pulse too long");
  a_start_while_busy: assert property ((O_CF_REQ || O_XFER_START) |-> O_BUSY)
    else $error("operation started without busy");
  a_busy_refuses: assert property (cmd_wr && O_BUSY |=> !O_CF_REQ && !O_XFER_START)
    else $error("command taken while busy");
  a_request_selected: assert property (O_CF_REQ && (O_CF_FUNC == FN_REQ) |-> $past(I_CF_SELECTED))
    else $error("drive request without formatter selected");
  a_test_length: assert property (O_XFER_START && O_XFER_TEST |-> O_XFER_LEN == TEST_WORDS)
    else $error("test transfer length wrong");
  a_addr_holds: assert property (!O_XFER_START |-> $stable(O_XFER_ADDR) && $stable(O_XFER_LEN))
    else $error("transfer set-up moved between starts");
  a_busy_ends: assert property ((I_CF_DONE || I_XFER_DONE) && O_BUSY |=> !O_BUSY)
    else $error("busy outlived completion");
  a_echo_issued: assert property (cmd_wr && !O_BUSY && I_PWDATA[8:0] == 9'h10F
    |=> O_CF_REQ && O_CF_FUNC == FN_CECHO)
    else $error("formatter echo not issued");
  a_unmapped_err: assert property (I_PSEL && I_PENABLE && I_PADDR[7:4] != 4'h0 |-> O_PSLVERR)
    else $error("unmapped access not flagged");
endmodule

bind dafd_top dafd_checker u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .I_CF_SELECTED(I_CF_SELECTED), .I_CF_DONE(I_CF_DONE), .I_XFER_DONE(I_XFER_DONE), .O_PSLVERR(O_PSLVERR),
  .O_CF_REQ(O_CF_REQ), .O_CF_FUNC(O_CF_FUNC), .O_XFER_START(O_XFER_START), .O_XFER_TEST(O_XFER_TEST),
  .O_XFER_LEN(O_XFER_LEN), .O_XFER_ADDR(O_XFER_ADDR), .O_BUSY(O_BUSY));

// [dafd_far_model.sv]
`timescale 1ns/1ps
// Far side: formatter echoes its write data, transfer engine ends after a pause
module dafd_far_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cf_req,
  input wire logic [15:0] i_cf_wdata,
  input wire logic i_xfer_start,
  output logic o_cf_done,
  output logic [15:0] o_cf_rdata,
  output logic o_xfer_done
);
  logic [3:0] cf_cnt; // Cycles before the formatter answers
  logic [3:0] xf_cnt; // Cycles before the transfer ends
  logic [15:0] echo; // Pattern handed back
  logic [15:0] noise; // Keeps the reply bus moving when no answer stands
  // Answer sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cf_cnt <= 4'h0;
      xf_cnt <= 4'h0;
      echo <= 16'h0000;
      noise <= 16'h0000;
      o_cf_done <= 1'b0;
      o_cf_rdata <= 16'h0000;
      o_xfer_done <= 1'b0;
    end else begin
      noise <= noise + 16'h3A59;
      o_cf_done <= 1'b0;
      o_xfer_done <= 1'b0;
      o_cf_rdata <= noise;
      // Odd patterns answer slowly, even ones promptly
      if (i_cf_req) begin
        echo <= i_cf_wdata;
        cf_cnt <= i_cf_wdata[0] ? 4'h8 : 4'h1;
      end else if (cf_cnt == 4'h1) begin
        o_cf_done <= 1'b1;
        o_cf_rdata <= echo;
        cf_cnt <= 4'h0;
      end else if (cf_cnt != 4'h0) begin
        cf_cnt <= cf_cnt - 4'h1;
      end
      // Transfer finishes three cycles after its start
      if (i_xfer_start) begin
        xf_cnt <= 4'h3;
      end else if (xf_cnt == 4'h1) begin
        o_xfer_done <= 1'b1;
        xf_cnt <= 4'h0;
      end else if (xf_cnt != 4'h0) begin
        xf_cnt <= xf_cnt - 4'h1;
      end
    end
  end
endmodule

// [tb_disk_adapter_function_decoder.sv]
`timescale 1ns/1ps
// Counts a check and reports a mismatch at once
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h vs %h", $time, g, e); end end
module tb_disk_adapter_function_decoder;
  import dafd_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, res, st;
  logic pready, pslverr, err, cf_sel = 1'b1, cf_done, cf_req, seek_err = 1'b0, ecc_load = 1'b0;
  logic [15:0] cf_rdata, cf_wdata, xfer_len, irq_en;
  logic [3:0] cf_func, cf_unit;
  logic [18:0] ecc_data = 19'h0_0000;
  logic [15:0] seek_end = 16'h0000;
  logic [6:0] stat_set = 7'h00;
  logic xfer_start, xfer_write, xfer_af, xfer_test, xfer_done, busy;
  logic [17:0] xfer_addr;
  int bad_count = 0, n_tests = 0;
  dafd_top u_dut (.I_CORE_CLK(core_clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CF_SELECTED(cf_sel), .I_CF_DONE(cf_done), .I_CF_RDATA(cf_rdata),
    .O_CF_REQ(cf_req), .O_CF_FUNC(cf_func), .O_CF_WDATA(cf_wdata), .O_CF_UNIT(cf_unit),
    .I_SEEK_END(seek_end), .I_SEEK_ERR(seek_err), .I_STATUS_SET(stat_set), .I_ECC_LOAD(ecc_load),
    .I_ECC_DATA(ecc_data), .O_XFER_START(xfer_start), .O_XFER_WRITE(xfer_write),
    .O_XFER_ADDR_FIELD(xfer_af), .O_XFER_TEST(xfer_test), .O_XFER_LEN(xfer_len),
    .O_XFER_ADDR(xfer_addr), .I_XFER_DONE(xfer_done), .O_IRQ_ENABLE(irq_en), .O_BUSY(busy));
  dafd_far_model u_far (.i_clk(core_clk), .i_rst_n(rst_n), .i_cf_req(cf_req), .i_cf_wdata(cf_wdata),
    .i_xfer_start(xfer_start), .o_cf_done(cf_done), .o_cf_rdata(cf_rdata), .o_xfer_done(xfer_done));
  // Clock at 100 MHz
  always #5 core_clk = ~core_clk;
  // Verdict and end of run
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One APB transfer; data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Parameter, command (optionally a second one at once), wait idle, fetch result and status
  task automatic op(input logic [15:0] p, input logic [8:0] c, input logic dup = 1'b0);
    apb(1'b1, OFS_PARAM, {16'h0000, p});
    apb(1'b1, OFS_CMD, {23'h00_0000, c});
    if (dup) apb(1'b1, OFS_CMD, 32'h0000_010F);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge core_clk);
    `CHK(busy, 1'b0)
    apb(1'b0, OFS_RESULT, 32'h0000_0000);
    res = q;
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    st = q;
  endtask
  // Quiet outputs after reset
  task automatic t_reset();
    `CHK({busy, cf_req, xfer_start}, 3'b000)
    `CHK(irq_en, 16'h0000)
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK(q[7:0], 8'h00)
  endtask
  // Formatter echo, then the same byte through the file registers
  task automatic t_echo();
    op(16'h005A, 9'h10F);
    `CHK(cf_func, FN_CECHO)
    `CHK(cf_wdata[7:0], 8'h5A)
    op(16'h005A, 9'h00F);
    `CHK(res[7:0], 8'h5A)
    op(16'h010F, 9'h10E);
    op(16'h0000, 9'h000);
    `CHK(res[7:0], 8'h5A)
  endtask
  // Drive request gating, busy refusal, director enables and reset
  task automatic t_director();
    cf_sel <= 1'b0;
    op(16'h0013, 9'h101);
    `CHK(st[5], 1'b1)
    cf_sel <= 1'b1;
    op(16'h0073, 9'h101, 1'b1);
    `CHK(cf_func, FN_REQ)
    `CHK(cf_wdata[6:0], 7'h73)
    op(16'h00C4, 9'h108);
    `CHK(irq_en, 16'h00C4)
    op(16'h0001, 9'h108);
    `CHK(st[5], 1'b0)
    `CHK(irq_en, 16'h0000)
  endtask
  // Test-mode transfers with an 18-bit start address, and refused parameters
  task automatic t_xfer();
    op(16'h0000, 9'h100);
    op(16'h1234, 9'h10D);
    op(16'h0003, 9'h10E);
    op(16'h0000, 9'h10A);
    `CHK({xfer_write, xfer_af, xfer_test}, 3'b101)
    `CHK(xfer_len, TEST_WORDS)
    `CHK(xfer_addr, 18'h3_1234)
    op(16'h0080, 9'h109);
    `CHK({xfer_write, xfer_af}, 2'b01)
    op(16'h0005, 9'h109);
    `CHK(st[5], 1'b1)
    op(16'h0001, 9'h108);
    op(16'h0003, 9'h106);
    `CHK(st[5], 1'b1)
    op(16'h0001, 9'h108);
  endtask
  // Drive echo needs its arming bit
  task automatic t_drive_echo();
    op(16'h0035, 9'h104);
    `CHK(st[5], 1'b1)
    op(16'h0001, 9'h108);
    op(16'h00B5, 9'h104);
    `CHK(cf_func, FN_DECHO)
    `CHK(cf_wdata[6:0], 7'h35)
    op(16'h00B5, 9'h004);
    `CHK(res[6:0], 7'h35)
  endtask
  // Seek error and home, unit select, seek, correction pattern, unmapped access
  task automatic t_seek_ecc();
    @(posedge core_clk);
    seek_err <= 1'b1;
    @(posedge core_clk);
    seek_err <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK(q[6], 1'b1)
    op(16'h0080, 9'h10C);
    `CHK(st[6], 1'b0)
    op(16'h0005, 9'h103);
    `CHK(cf_unit, 4'h5)
    op(16'h0123, 9'h105);
    `CHK(cf_func, FN_CYL)
    `CHK(cf_wdata, 16'h0123)
    ecc_data <= 19'h7_A800;
    ecc_load <= 1'b1;
    @(posedge core_clk);
    ecc_load <= 1'b0;
    op(16'h0000, 9'h00A);
    `CHK(res[7:0], 8'hF5)
    op(16'h0020, 9'h10B);
    op(16'h0000, 9'h00A);
    `CHK(res[7:0], 8'h00)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
  endtask
  // Head/sector store, masked status clear, per-drive seek flags on unit 5
  task automatic t_status();
    op(16'h1A2B, 9'h107);
    op(16'h0000, 9'h007);
    `CHK(res[15:0], 16'h1A2B)
    @(posedge core_clk);
    stat_set <= 7'h45;
    @(posedge core_clk);
    stat_set <= 7'h00;
    op(16'h0004, 9'h10C);
    op(16'h0000, 9'h008);
    `CHK(res[6:0], 7'h41)
    op(16'h0000, 9'h002);
    `CHK(res[15:0], 16'h2000)
    @(posedge core_clk);
    seek_end <= 16'h0020;
    @(posedge core_clk);
    seek_end <= 16'h0000;
    op(16'h0000, 9'h002);
    `CHK(res[15:0], 16'h0020)
    op(16'h0005, 9'h105);
    op(16'h0000, 9'h002);
    `CHK(res[15:0], 16'h2000)
    op(16'h0045, 9'h101);
    `CHK(cf_unit, 4'h5)
    op(16'h0000, 9'h002);
    `CHK(res[15:0], 16'h0000)
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_echo();
    t_director();
    t_xfer();
    t_drive_echo();
    t_seek_ecc();
    t_status();
    close_out();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
endmodule
